// File: rtl/fid_pkg.sv
// constants and carrier types for the 14-bit instruction decode and execute core
// Summary of operation
// - bit clear/set read whole register, change one bit, write all eight back
// - OR, AND, XOR of accumulator with file (0100/0101/0110) change only zero flag
// - dec_skip_zero decrements to destination; zero result discards next word
// - inc_skip_zero increments to destination; zero result skips next; flags untouched
// - rotate left/right through carry; only carry flag changes
// - bit word: prefix 01, op, bit index, address; test_skip_clear skips on zero
// - test_skip_set discards next fetched word and runs a no-op when bit is one
// - program counter change or true test costs two cycles, second a no-op
// - port register operand read from pin levels, not the output latch
// - read-modify-write on timer_zero_count clears prescaler when assigned to timer
// - add_lit_acc adds literal to accumulator, updates carry, nibble carry, zero
// - and_lit_acc ANDs literal into accumulator, only zero flag changes
// - or_lit_acc ORs literal into accumulator, only zero flag changes
// - sub_lit_acc computes literal minus accumulator, updates carry, nibble carry, zero
// - return_lit loads literal into accumulator and pops return address, two cycles
// - subroutine return pops top of stack into program counter, two cycles
// - return_interrupt pops program counter, re-enables global interrupts, two cycles
// - standby word enters sleep in one cycle, sets expired bit, clears sleep bit
// - destination bit zero writes accumulator, one writes the file register
// - one instruction cycle spans four clocks
package fid_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_CALC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  // ****************************************
  // opcode groups and codes
  // ****************************************
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_CTRL = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;

  localparam logic [3:0] NB_MOVE_ACC = 4'h0;
  localparam logic [3:0] NB_CLEAR = 4'h1;
  localparam logic [3:0] NB_SUB = 4'h2;
  localparam logic [3:0] NB_DEC = 4'h3;
  localparam logic [3:0] NB_OR = 4'h4;
  localparam logic [3:0] NB_AND = 4'h5;
  localparam logic [3:0] NB_XOR = 4'h6;
  localparam logic [3:0] NB_ADD = 4'h7;
  localparam logic [3:0] NB_MOVE = 4'h8;
  localparam logic [3:0] NB_COMP = 4'h9;
  localparam logic [3:0] NB_INC = 4'ha;
  localparam logic [3:0] NB_DEC_SKIP = 4'hb;
  localparam logic [3:0] NB_ROT_RIGHT = 4'hc;
  localparam logic [3:0] NB_ROT_LEFT = 4'hd;
  localparam logic [3:0] NB_SWAP = 4'he;
  localparam logic [3:0] NB_INC_SKIP = 4'hf;

  localparam logic [1:0] BO_CLEAR = 2'h0;
  localparam logic [1:0] BO_SET = 2'h1;
  localparam logic [1:0] BO_TEST_CLR = 2'h2;
  localparam logic [1:0] BO_TEST_SET = 2'h3;

  // move and return match the top two nibble bits, subtract and add the top three
  localparam logic [1:0] LN_MOVE = 2'h0;
  localparam logic [1:0] LN_RETURN = 2'h1;
  localparam logic [3:0] LN_OR = 4'h8;
  localparam logic [3:0] LN_AND = 4'h9;
  localparam logic [3:0] LN_XOR = 4'ha;
  localparam logic [2:0] LN_SUB = 3'h6;
  localparam logic [2:0] LN_ADD = 3'h7;

  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_RET_INT = 14'h0009;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_WDT_CLR = 14'h0064;
  localparam logic [13:0] W_NOP = 14'h0000;

  // ****************************************
  // file addresses, sizes and reset values
  // ****************************************
  localparam logic [6:0] A_TIMER_ZERO = 7'h01;
  localparam logic [6:0] A_PORT_FIRST = 7'h05;
  localparam logic [6:0] A_PORT_LAST = 7'h09;
  localparam int STACK_DEPTH = 8;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [7:0] RST_ACC = 8'h00;

  typedef struct packed {
    logic [6:0] addr;
    logic wrEn;
    logic [7:0] wrData;
  } fid_fbus_t;

  typedef struct packed {
    logic expired;
    logic sleepN;
    logic z;
    logic nibCarry;
    logic c;
  } fid_flags_t;

endpackage

// File: rtl/fid_core.sv
// instruction decode and execute core for a 14-bit instruction word set
module fid_core (
  input wire logic sys_clk,
  input wire logic sys_rst,
  output logic [12:0] progAddr,
  input wire logic [13:0] progWord,
  input wire logic [1:0] pageSel,
  output fid_pkg::fid_fbus_t fileBus,
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] pinLevels,
  input wire logic prescAssigned,
  output logic prescClr,
  input wire logic wakeReq,
  input wire logic gieClr,
  output logic [7:0] accOut,
  output fid_pkg::fid_flags_t flagsOut,
  output logic gieOut,
  output logic sleepOut
);

  logic [1:0] qQ;
  logic [13:0] irQ;
  logic flushQ;
  logic sleepQ;
  logic [12:0] pcQ;
  logic [7:0] accQ;
  logic [7:0] opQ;
  fid_pkg::fid_flags_t flagsQ;
  logic gieQ;
  logic prescClrQ;
  fid_pkg::fid_fbus_t fileBusQ;
  logic [12:0] stkMem [fid_pkg::STACK_DEPTH];
  logic [2:0] spQ;
  logic [7:0] pinS1Q, pinS2Q, pinS3Q, pinStableQ;

  logic exec;
  logic [1:0] grp;
  logic [3:0] nib;
  logic dBit;
  logic [2:0] bIdx;
  logic [6:0] fAd;
  logic [7:0] lit;
  logic [7:0] mask;
  logic isPort;
  logic [12:0] stackTop;

  logic [7:0] res, resFinal, addA, addB;
  logic cin, useSum, wrF, wrA, updZ, updC, updNibC, cNew;
  logic skip, jump, push, pop, retInt, goSleep, goWdt, rmwF, isLogic, isRot;
  logic [8:0] sum9;
  logic [4:0] nib5;

  assign exec = !flushQ && !sleepQ;
  assign grp = irQ[13:12];
  assign nib = irQ[11:8];
  assign dBit = irQ[7];
  assign bIdx = irQ[9:7];
  assign fAd = irQ[6:0];
  assign lit = irQ[7:0];
  assign mask = 8'h01 << bIdx;
  assign isPort = (fAd >= fid_pkg::A_PORT_FIRST) && (fAd <= fid_pkg::A_PORT_LAST);
  assign stackTop = stkMem[spQ - 3'h1];

  // ****************************************
  // instruction decode and arithmetic
  // ****************************************
  always_comb begin
    res = opQ;
    addA = opQ;
    addB = accQ;
    cin = 1'b0;
    useSum = 1'b0;
    wrF = 1'b0;
    wrA = 1'b0;
    updZ = 1'b0;
    updC = 1'b0;
    updNibC = 1'b0;
    cNew = flagsQ.c;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    retInt = 1'b0;
    goSleep = 1'b0;
    goWdt = 1'b0;
    rmwF = 1'b0;
    isLogic = 1'b0;
    isRot = 1'b0;
    case (grp)
      fid_pkg::GRP_BYTE: begin
        wrF = dBit;
        wrA = !dBit;
        rmwF = dBit;
        case (nib)
          fid_pkg::NB_MOVE_ACC: begin
            res = accQ;
            wrA = 1'b0;
            rmwF = 1'b0;
            case (irQ)
              fid_pkg::W_RETURN: begin
                pop = 1'b1;
                jump = 1'b1;
              end
              fid_pkg::W_RET_INT: begin
                pop = 1'b1;
                jump = 1'b1;
                retInt = 1'b1;
              end
              fid_pkg::W_SLEEP: goSleep = 1'b1;
              fid_pkg::W_WDT_CLR: goWdt = 1'b1;
              default: ;
            endcase
          end
          fid_pkg::NB_CLEAR: begin
            res = 8'h00;
            updZ = 1'b1;
          end
          fid_pkg::NB_SUB: begin
            addB = ~accQ;
            cin = 1'b1;
            useSum = 1'b1;
            {updZ, updC, updNibC} = 3'h7;
          end
          fid_pkg::NB_DEC: begin
            res = opQ - 8'h01;
            updZ = 1'b1;
          end
          fid_pkg::NB_OR: begin
            res = accQ | opQ;
            updZ = 1'b1;
            isLogic = 1'b1;
          end
          fid_pkg::NB_AND: begin
            res = accQ & opQ;
            updZ = 1'b1;
            isLogic = 1'b1;
          end
          fid_pkg::NB_XOR: begin
            res = accQ ^ opQ;
            updZ = 1'b1;
            isLogic = 1'b1;
          end
          fid_pkg::NB_ADD: begin
            useSum = 1'b1;
            {updZ, updC, updNibC} = 3'h7;
          end
          fid_pkg::NB_MOVE: updZ = 1'b1;
          fid_pkg::NB_COMP: begin
            res = ~opQ;
            updZ = 1'b1;
          end
          fid_pkg::NB_INC: begin
            res = opQ + 8'h01;
            updZ = 1'b1;
          end
          fid_pkg::NB_DEC_SKIP: begin
            res = opQ - 8'h01;
            skip = (res == 8'h00);
          end
          fid_pkg::NB_ROT_RIGHT: begin
            res = {flagsQ.c, opQ[7:1]};
            cNew = opQ[0];
            updC = 1'b1;
            isRot = 1'b1;
          end
          fid_pkg::NB_ROT_LEFT: begin
            res = {opQ[6:0], flagsQ.c};
            cNew = opQ[7];
            updC = 1'b1;
            isRot = 1'b1;
          end
          fid_pkg::NB_SWAP: res = {opQ[3:0], opQ[7:4]};
          fid_pkg::NB_INC_SKIP: begin
            res = opQ + 8'h01;
            skip = (res == 8'h00);
          end
          default: ;
        endcase
      end
      fid_pkg::GRP_BIT: begin
        case (irQ[11:10])
          fid_pkg::BO_CLEAR: begin
            res = opQ & ~mask;
            wrF = 1'b1;
            rmwF = 1'b1;
          end
          fid_pkg::BO_SET: begin
            res = opQ | mask;
            wrF = 1'b1;
            rmwF = 1'b1;
          end
          fid_pkg::BO_TEST_CLR: skip = ((opQ & mask) == 8'h00);
          fid_pkg::BO_TEST_SET: skip = ((opQ & mask) != 8'h00);
          default: ;
        endcase
      end
      fid_pkg::GRP_CTRL: begin
        jump = 1'b1;
        push = !irQ[11];
      end
      fid_pkg::GRP_LIT: begin
        wrA = 1'b1;
        if (nib[3:2] == fid_pkg::LN_MOVE) begin
          res = lit;
        end else if (nib[3:2] == fid_pkg::LN_RETURN) begin
          res = lit;
          pop = 1'b1;
          jump = 1'b1;
        end else if (nib == fid_pkg::LN_OR) begin
          res = accQ | lit;
          updZ = 1'b1;
          isLogic = 1'b1;
        end else if (nib == fid_pkg::LN_AND) begin
          res = accQ & lit;
          updZ = 1'b1;
          isLogic = 1'b1;
        end else if (nib == fid_pkg::LN_XOR) begin
          res = accQ ^ lit;
          updZ = 1'b1;
          isLogic = 1'b1;
        end else if (nib[3:1] == fid_pkg::LN_SUB) begin
          addA = lit;
          addB = ~accQ;
          cin = 1'b1;
          useSum = 1'b1;
          {updZ, updC, updNibC} = 3'h7;
        end else if (nib[3:1] == fid_pkg::LN_ADD) begin
          addA = lit;
          useSum = 1'b1;
          {updZ, updC, updNibC} = 3'h7;
        end else begin
          wrA = 1'b0;
        end
      end
      default: ;
    endcase
  end

  // carry out of the subtract path means no borrow
  assign sum9 = {1'b0, addA} + {1'b0, addB} + {8'h00, cin};
  assign nib5 = {1'b0, addA[3:0]} + {1'b0, addB[3:0]} + {4'h0, cin};
  assign resFinal = useSum ? sum9[7:0] : res;

  // ****************************************
  // pin synchroniser and phase counter
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinS1Q <= 8'h00;
      pinS2Q <= 8'h00;
      pinS3Q <= 8'h00;
      pinStableQ <= 8'h00;
    end else begin
      pinS1Q <= pinLevels;
      pinS2Q <= pinS1Q;
      pinS3Q <= pinS2Q;
      if (pinS2Q == pinS3Q) begin
        pinStableQ <= pinS3Q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      qQ <= fid_pkg::PH_DECODE;
    end else begin
      qQ <= qQ + 2'h1;
    end
  end

  // ****************************************
  // operand read and file write
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opQ <= 8'h00;
    end else if (qQ == fid_pkg::PH_READ) begin
      opQ <= isPort ? pinStableQ : fileRdData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fileBusQ <= '0;
      prescClrQ <= 1'b0;
    end else begin
      case (qQ)
        fid_pkg::PH_DECODE: fileBusQ.addr <= fAd;
        fid_pkg::PH_CALC: begin
          fileBusQ.wrEn <= exec && wrF;
          fileBusQ.wrData <= resFinal;
          prescClrQ <= exec && rmwF && (fAd == fid_pkg::A_TIMER_ZERO) && prescAssigned;
        end
        fid_pkg::PH_WRITE: begin
          fileBusQ.wrEn <= 1'b0;
          prescClrQ <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // accumulator, flags and control state
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      accQ <= fid_pkg::RST_ACC;
      flagsQ <= '{expired: 1'b1, sleepN: 1'b1, z: 1'b0, nibCarry: 1'b0, c: 1'b0};
    end else if (qQ == fid_pkg::PH_WRITE && exec) begin
      if (wrA) begin
        accQ <= resFinal;
      end
      if (updZ) begin
        flagsQ.z <= (resFinal == 8'h00);
      end
      if (updC) begin
        flagsQ.c <= useSum ? sum9[8] : cNew;
      end
      if (updNibC) begin
        flagsQ.nibCarry <= nib5[4];
      end
      if (goSleep || goWdt) begin
        flagsQ.expired <= 1'b1;
        flagsQ.sleepN <= goWdt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleepQ <= 1'b0;
      gieQ <= 1'b0;
    end else begin
      if (qQ == fid_pkg::PH_WRITE && exec && goSleep) begin
        sleepQ <= 1'b1;
      end else if (wakeReq) begin
        sleepQ <= 1'b0;
      end
      // the return sets the enable even if a clear arrives together
      if (qQ == fid_pkg::PH_WRITE && exec && retInt) begin
        gieQ <= 1'b1;
      end else if (gieClr) begin
        gieQ <= 1'b0;
      end
    end
  end

  // ****************************************
  // fetch, program counter and stack
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pcQ <= fid_pkg::RST_PC;
      irQ <= fid_pkg::W_NOP;
      flushQ <= 1'b0;
      spQ <= 3'h0;
    end else if (qQ == fid_pkg::PH_WRITE && !sleepQ) begin
      irQ <= progWord;
      // the prefetched word is turned into a no-op on any branch or skip
      flushQ <= exec && (jump || skip);
      if (exec && pop) begin
        pcQ <= stackTop;
        spQ <= spQ - 3'h1;
      end else if (exec && jump) begin
        pcQ <= {pageSel, irQ[10:0]};
        if (push) begin
          spQ <= spQ + 3'h1;
        end
      end else begin
        pcQ <= pcQ + 13'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (qQ == fid_pkg::PH_WRITE && exec && jump && push) begin
      stkMem[spQ] <= pcQ;
    end
  end

  assign progAddr = pcQ;
  assign fileBus = fileBusQ;
  assign prescClr = prescClrQ;
  assign accOut = accQ;
  assign flagsOut = flagsQ;
  assign gieOut = gieQ;
  assign sleepOut = sleepQ;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence sPhaseRun;
    qQ == fid_pkg::PH_DECODE ##1 qQ == fid_pkg::PH_READ ##1 qQ == fid_pkg::PH_CALC
      ##1 qQ == fid_pkg::PH_WRITE;
  endsequence

  sequence sNopCycle;
    flushQ [*4];
  endsequence

  a_cycle_four_phases: assert property (
    qQ == fid_pkg::PH_DECODE |-> sPhaseRun) else $error("instruction cycle not four clocks");

  a_skip_then_nop: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && (skip || jump) && !sleepQ) |=> sNopCycle
    ##1 !flushQ) else $error("second cycle not a no-op");

  a_count_skip: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && grp == fid_pkg::GRP_BYTE && nib[1:0] == 2'h3
     && nib[3] && resFinal == 8'h00) |=> flushQ) else $error("count skip missed");

  a_test_skip: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && grp == fid_pkg::GRP_BIT && irQ[11]
     && ((opQ & mask) != 8'h00) == irQ[10]) |=> flushQ) else $error("bit test skip missed");

  a_bit_rmw_write: assert property (
    (qQ == fid_pkg::PH_CALC && exec && grp == fid_pkg::GRP_BIT && !irQ[11])
    |=> fileBusQ.wrEn && (fileBusQ.wrData & ~$past(mask)) == ($past(opQ) & ~$past(mask))
    && ((fileBusQ.wrData & $past(mask)) != 8'h00) == $past(irQ[10]))
    else $error("bit write disturbed other bits");

  a_logic_zero_only: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && isLogic) |=> flagsQ.c == $past(flagsQ.c)
    && flagsQ.nibCarry == $past(flagsQ.nibCarry) && flagsQ.z == ($past(resFinal) == 8'h00))
    else $error("logic op touched wrong flags");

  a_rotate_carry: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && isRot) |=> flagsQ.z == $past(flagsQ.z)
    && flagsQ.c == ($past(irQ[8]) ? $past(opQ[7]) : $past(opQ[0])))
    else $error("rotate carry wrong");

  a_pin_operand: assert property (
    (qQ == fid_pkg::PH_READ && isPort) |=> opQ == $past(pinStableQ))
    else $error("port operand not from pins");

  a_presc_clear: assert property (
    (qQ == fid_pkg::PH_CALC && exec && rmwF && fAd == fid_pkg::A_TIMER_ZERO && prescAssigned)
    |=> prescClrQ ##1 !prescClrQ) else $error("prescaler clear pulse wrong");

  a_lit_add_acc: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && grp == fid_pkg::GRP_LIT && nib[3:1] == 3'h7)
    |=> accQ == $past(accQ) + $past(lit)) else $error("literal add result wrong");

  a_return_pop: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && pop) |=> pcQ == $past(stackTop)
    && spQ == $past(spQ) - 3'h1) else $error("return did not pop");

  a_int_return_gie: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && retInt) |=> gieQ && flushQ)
    else $error("interrupt return left enable low");

  a_sleep_entry: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && goSleep) |=> sleepQ && flagsQ.expired
    && !flagsQ.sleepN) else $error("standby flags wrong");

  a_call_push: assert property (
    (qQ == fid_pkg::PH_WRITE && exec && jump && push) |=> stkMem[$past(spQ)] == $past(pcQ)
    && pcQ[10:0] == $past(irQ[10:0])) else $error("call push or target wrong");

endmodule // fid_core

// File: bench/fid_mem_model.sv
// program memory and file register model facing the core
module fid_mem_model (
  input wire logic sys_clk,
  input wire logic [12:0] progAddr,
  output logic [13:0] progWord,
  input wire fid_pkg::fid_fbus_t fileBus,
  output logic [7:0] fileRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] prog [64];
  logic [7:0] regs [128];
  // combinational reads: word and operand are valid well before their sampling edges
  assign progWord = prog[progAddr[5:0]];
  assign fileRdData = regs[fileBus.addr];
  always @(posedge sys_clk) begin
    if (fileBus.wrEn === 1'h1) begin
      regs[fileBus.addr] <= fileBus.wrData;
    end
  end
endmodule // fid_mem_model

// File: bench/tb.sv
// self-checking bench for the instruction decode and execute core
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, prescAssigned, wakeReq, gieClr, prescClr, gieOut, sleepOut;
  logic [7:0] pinLevels, fileRdData, accOut, a, k, v, r8;
  logic [12:0] progAddr, lastPc;
  logic [1:0] pageSel;
  logic [13:0] progWord;
  logic [13:0] pw [6];
  fid_pkg::fid_fbus_t fileBus;
  fid_pkg::fid_flags_t flagsOut;
  logic [10:0] r1, r2;
  logic [6:0] f;
  logic [2:0] b;
  logic d, sk, seen, slept;
  integer seed = 13;
  int failures = 0, checks = 0, cyc = 0, pulses = 0, hold = 0, op;
  logic [3:0] litNib [5] = '{4'he, 4'hc, 4'h9, 4'h8, 4'ha};
  logic [3:0] fNib [5] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6};
  logic [13:0] w4 [4] = '{14'h3444, 14'h3010, 14'h3010, 14'h3010};
  logic [13:0] w5 [4] = '{14'h0, fid_pkg::W_RETURN, 14'h2802, fid_pkg::W_RET_INT};
  logic [7:0] eAcc [4] = '{8'h45, 8'h11, 8'h10, 8'h11};

  fid_core i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .progAddr(progAddr),
    .progWord(progWord), .pageSel(pageSel), .fileBus(fileBus), .fileRdData(fileRdData),
    .pinLevels(pinLevels), .prescAssigned(prescAssigned), .prescClr(prescClr),
    .wakeReq(wakeReq), .gieClr(gieClr), .accOut(accOut), .flagsOut(flagsOut),
    .gieOut(gieOut), .sleepOut(sleepOut));
  fid_mem_model i_mem (.sys_clk(sys_clk), .progAddr(progAddr), .progWord(progWord),
    .fileBus(fileBus), .fileRdData(fileRdData));

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************
  // checking
  // ****************************************
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chkSt(logic [7:0] ea, logic [4:0] ef);
    chk("acc", 16'(ea), 16'(accOut));
    chk("flags", 16'(ef), 16'(flagsOut));
  endtask

  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [13:0] bw(logic [3:0] n, logic dd, logic [6:0] ff);
    return {2'h0, n, dd, ff};
  endfunction

  function automatic logic [13:0] bb(logic [1:0] o, logic [2:0] bi, logic [6:0] ff);
    return {2'h1, o, bi, ff};
  endfunction

  function automatic logic [13:0] lw(logic [3:0] n, logic [7:0] kk);
    return {2'h3, n, kk};
  endfunction

  // returns {z, nibble carry, carry, result}; dcc is the incoming carry pair
  function automatic logic [10:0] calc(int o, logic [7:0] w, logic [7:0] kk, logic [1:0] dcc);
    logic [8:0] s;
    case (o)
      0: begin
        s = w + kk;
        dcc = {({1'h0, w[3:0]} + {1'h0, kk[3:0]}) > 5'hf, s[8]};
      end
      1: begin
        s = kk - w;
        dcc = {kk[3:0] >= w[3:0], ~s[8]};
      end
      2: s = {1'h0, w & kk};
      3: s = {1'h0, w | kk};
      default: s = {1'h0, w ^ kk};
    endcase
    return {s[7:0] == 8'h0, dcc, s[7:0]};
  endfunction

  task automatic rnd();
    a = 8'($random(seed));
    k = 8'($random(seed));
    v = 8'($random(seed));
    d = 1'($random(seed));
    f = {2'h1, 5'($random(seed))};
  endtask

  // load program and operand, reset, then run fifteen instruction cycles
  task automatic go();
    for (int j = 0; j < 64; j++) begin
      i_mem.prog[j] = (j < 6) ? pw[j] : fid_pkg::W_NOP;
    end
    i_mem.regs[f] = v;
    sys_rst = 1'h1;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'h0;
    repeat (60) @(negedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (prescClr === 1'h1) pulses++;
    if (sys_rst) begin
      seen = 1'h0;
      slept = 1'h0;
      hold = 0;
    end else begin
      hold++;
      if (sleepOut === 1'h1) slept = 1'h1;
      if (progAddr !== lastPc) begin
        if (seen && !slept) chk("pcHold", 16'(fid_pkg::OSC_PER_CYCLE), 16'(hold));
        seen = 1'h1;
        hold = 0;
      end
    end
    lastPc = progAddr;
    if (cyc == 8000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    sys_rst = 1'h1;
    pinLevels = 8'h0;
    prescAssigned = 1'h0;
    wakeReq = 1'h0;
    gieClr = 1'h0;
    pageSel = 2'h0;
    // literal ops after an add, first rounds with an all-carry add
    for (int i = 0; i < 10; i++) begin
      rnd();
      op = i % 5;
      if (i < 5) {a, k} = 16'hff01;
      r1 = calc(0, a, k, 2'h0);
      r2 = calc(op, r1[7:0], v, r1[9:8]);
      pw = '{lw(4'h0, a), lw(4'he, k), lw(litNib[op], v), 14'h0, 14'h0, 14'h0};
      go();
      chkSt(r2[7:0], {2'h3, r2[10:8]});
    end
    // byte ops with a file: add, subtract, and, or, xor
    for (int i = 0; i < 10; i++) begin
      rnd();
      op = i % 5;
      r1 = calc(op, a, v, 2'h0);
      pw = '{lw(4'h0, a), bw(fNib[op], d, f), 14'h0, 14'h0, 14'h0, 14'h0};
      go();
      chkSt(d ? a : r1[7:0], {2'h3, r1[10:8]});
      chk("file", 16'(d ? r1[7:0] : v), 16'(i_mem.regs[f]));
    end
    for (int i = 0; i < 6; i++) begin
      rnd();
      op = i % 2;
      if (i < 4) v = op ? 8'hff : 8'h01;
      r8 = op ? v + 8'h1 : v - 8'h1;
      sk = r8 == 8'h0;
      pw = '{bw(op ? 4'hf : 4'hb, d, f), lw(4'h8, 8'h80), 14'h0, 14'h0, 14'h0, 14'h0};
      go();
      chkSt((d ? 8'h0 : r8) | (sk ? 8'h0 : 8'h80), 5'h18);
      chk("file", 16'(d ? r8 : v), 16'(i_mem.regs[f]));
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      op = i % 2;
      r1 = calc(0, a, k, 2'h0);
      r8 = op ? {v[6:0], r1[8]} : {r1[8], v[7:1]};
      pw = '{lw(4'h0, a), lw(4'he, k), bw(op ? 4'hd : 4'hc, d, f), 14'h0, 14'h0, 14'h0};
      go();
      chkSt(d ? r1[7:0] : r8, {2'h3, r1[10:9], op ? v[7] : v[0]});
      chk("file", 16'(d ? r8 : v), 16'(i_mem.regs[f]));
    end
    // every bit operation sees the selected bit both clear and set
    for (int i = 0; i < 8; i++) begin
      rnd();
      op = i % 4;
      b = 3'($random(seed));
      v[b] = i[2];
      r8 = (op == 0) ? v & ~(8'h1 << b) : (op == 1) ? v | (8'h1 << b) : v;
      sk = (op == 2 && !v[b]) || (op == 3 && v[b]);
      pw = '{bb(2'(op), b, f), lw(4'h8, 8'h80), 14'h0, 14'h0, 14'h0, 14'h0};
      go();
      chkSt(sk ? 8'h0 : 8'h80, 5'h18);
      chk("file", 16'(r8), 16'(i_mem.regs[f]));
    end
    pinLevels = 8'($random(seed));
    v = ~pinLevels;
    f = 7'h06;
    pw = '{lw(4'h0, 8'h0), bw(4'h4, 1'h1, f), 14'h0, 14'h0, 14'h0, 14'h0};
    go();
    chk("port", 16'(pinLevels), 16'(i_mem.regs[6]));
    for (int i = 0; i < 2; i++) begin
      prescAssigned = i[0];
      f = 7'h01;
      v = 8'h0;
      pulses = 0;
      pw = '{bb(2'h1, 3'h3, f), 14'h0, 14'h0, 14'h0, 14'h0, 14'h0};
      go();
      chk("presc", 16'(i), 16'(pulses));
      chk("timer", 16'h8, 16'(i_mem.regs[1]));
    end
    // call, returns and jump; the word after a taken branch must never run
    for (int i = 0; i < 4; i++) begin
      pageSel = 2'(i);
      pw = '{i == 2 ? 14'h2804 : 14'h2004, lw(4'he, 8'h1), 14'h2802, lw(4'h0, 8'h77),
        w4[i], w5[i]};
      go();
      chkSt(eAcc[i], 5'h18);
      chk("gie", 16'(i == 3), 16'(gieOut));
      chk("page", 16'(i), 16'(progAddr[12:11]));
    end
    gieClr = 1'h1;
    @(negedge sys_clk);
    gieClr = 1'h0;
    @(negedge sys_clk);
    chk("gie", 16'h0, 16'(gieOut));
    pw = '{fid_pkg::W_SLEEP, lw(4'h0, 8'h66), fid_pkg::W_WDT_CLR, 14'h0, 14'h0, 14'h0};
    go();
    chkSt(8'h0, 5'h10);
    chk("sleep", 16'h1, 16'(sleepOut));
    wakeReq = 1'h1;
    @(negedge sys_clk);
    wakeReq = 1'h0;
    repeat (20) @(negedge sys_clk);
    chk("wake", 16'h66, 16'(accOut));
    chk("wdt", 16'h18, 16'(flagsOut));
    final_report();
  end
endmodule // tb
